/* verilog/memory_ctrl_status_and_comp_regs.sv */
/*
  memory_ctrl_status_and_comp_regs: register bank of the dynamic memory
  controller covering interrupt enable and status, strobe delay status,
  pin interface control and pad compensation control.
  Assumes all event inputs are synchronous one-cycle pulses on clk and
  the bus master follows Avalon-MM with waitrequest.

  // Summary of operation
  // - irq_enable holds enables for compensation, offset range and delay programmed at 31..29.
  // - an event sets its status flag whatever its enable says; enables gate only irq.
  // - irq_status holds all three event flags in bits 31..29.
  // - strobe_delay_status is read-only and shows the delays applied to the strobe lines.
  // - each strobe field always equals the value loaded in its delay line, whoever set it.
  // - each strobe field counts the delay elements selected in that line.
  // - a counter on the 13 MHz reference schedules compensation evaluations.
  // - software starts an evaluation by a register bit, as it does a refresh.
  // - pin_interface_ctrl drives strobe pulls and command and data pad hysteresis.
  // - pad drive settings stay as they were until software sets the update bit.
  // - an update forces four idle cycles on the memory interface and loads the pads inside.
*/
`default_nettype none
`timescale 1ns/1ps

module memory_ctrl_status_and_comp_regs
  import memory_ctrl_pkg::*;
#(
  parameter int DRIVE_W = 32
) (
  input  wire logic                                     clk,
  input  wire logic                                     reset,
  input  wire logic [7:0]                               avs_address,
  input  wire logic                                     avs_read,
  input  wire logic                                     avs_write,
  input  wire logic [31:0]                              avs_writedata,
  input  wire logic [3:0]                               avs_byteenable,
  output logic [31:0]                                   avs_readdata,
  output logic                                          avs_waitrequest,
  output logic                                          irq,
  input  wire logic                                     ref_tick,
  output logic                                          eval_start,
  input  wire logic                                     eval_done,
  input  wire comp_codes_t                              eval_codes,
  input  wire logic [CODE_W-1:0]                        phase_value,
  input  wire logic [CODE_W-1:0]                        offset_value,
  input  wire logic                                     self_refresh_flag,
  input  wire logic                                     offset_out_of_range,
  input  wire logic                                     delay_programmed,
  input  wire logic [STROBE_N-1:0][STROBE_FIELD_W-1:0]  strobe_delay_value,
  input  wire logic [DRIVE_W-1:0]                       pad_drive_pending,
  output logic [DRIVE_W-1:0]                            pad_drive_applied,
  output logic                                          nop_insert,
  output pin_ctrl_t                                     pin_ctrl
);

  // merge a bus write into a register under the byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // true when a code moved further than the allowed window from its last value
  function automatic logic code_out_of_range(input logic [CODE_W-1:0]       old_c,
                                             input logic [CODE_W-1:0]       new_c,
                                             input logic [COMP_RANGE_W-1:0] rng);
    logic [CODE_W:0] hi;
    logic [CODE_W:0] lo_new;
    hi     = {1'b0, old_c} + {{(CODE_W+1-COMP_RANGE_W){1'b0}}, rng};
    lo_new = {1'b0, new_c} + {{(CODE_W+1-COMP_RANGE_W){1'b0}}, rng};
    return ({1'b0, new_c} > hi) || (lo_new < {1'b0, old_c});
  endfunction

  // writable masks: reserved bits never take a write
  localparam logic [31:0] IRQ_MASK   = 32'hE000_0000;
  localparam logic [31:0] PIN_MASK   = 32'hF400_0000;
  localparam logic [31:0] COMP_MASK  = 32'hFF0F_FFFF;

  logic [31:0]         irq_enable_reg;
  logic [31:0]         pin_if_ctrl_reg;
  logic [31:0]         pad_comp_ctrl_reg;
  logic [31:0]         pad_comp_ctrl_next;
  irq_vec_t            flags_reg;
  irq_vec_t            flags_next;
  comp_codes_t         codes_reg;
  logic [31:0]         readdata_reg;
  logic                ack_reg;
  logic [DRIVE_W-1:0]  pad_drive_applied_reg;

  // bus decode
  wire        req        = avs_read || avs_write;
  wire        wr_edge    = avs_write && ack_reg;
  wire        rd_edge    = avs_read && ack_reg;
  wire [7:0]  word_addr  = {avs_address[7:2], 2'b00};
  wire        sel_en     = (word_addr == OFS_IRQ_ENABLE);
  wire        sel_sts    = (word_addr == OFS_IRQ_STATUS);
  wire        sel_dly    = (word_addr == OFS_STROBE_DELAY);
  wire        sel_pin    = (word_addr == OFS_PIN_IF_CTRL);
  wire        sel_comp   = (word_addr == OFS_PAD_COMP_CTRL);
  wire        wr_en      = wr_edge && sel_en;
  wire        wr_sts     = wr_edge && sel_sts;
  wire        wr_pin     = wr_edge && sel_pin;
  wire        wr_comp    = wr_edge && sel_comp;
  wire        rd_sts     = rd_edge && sel_sts;

  // one wait state: the answer is always ready in the second cycle
  assign avs_waitrequest = req && !ack_reg;
  assign avs_readdata    = readdata_reg;

  // compensation control fields
  wire                         sw_trigger = pad_comp_ctrl_reg[COMP_SW_EVAL_BIT];
  wire                         update_bit = pad_comp_ctrl_reg[COMP_UPDATE_BIT];
  wire [COMP_RANGE_W-1:0]      comp_range =
                                 pad_comp_ctrl_reg[COMP_RANGE_LSB +: COMP_RANGE_W];
  wire [EVAL_INTERVAL_W-1:0]   eval_interval = pad_comp_ctrl_reg[EVAL_INTERVAL_W-1:0];

  logic eval_busy;
  logic sw_done;
  logic pad_load;
  logic update_done;

  comp_eval_sched #(
    .INTERVAL_W (EVAL_INTERVAL_W)
  ) u_sched (
    .clk        (clk),
    .reset      (reset),
    .ref_tick   (ref_tick),
    .interval   (eval_interval),
    .sw_trigger (sw_trigger),
    .eval_done  (eval_done),
    .eval_start (eval_start),
    .eval_busy  (eval_busy),
    .sw_done    (sw_done)
  );

  pad_update_seq #(
    .NOP_CYCLES (PAD_NOP_CYCLES),
    .LOAD_AT    (PAD_LOAD_AT)
  ) u_pad (
    .clk         (clk),
    .reset       (reset),
    .update_req  (update_bit),
    .nop_insert  (nop_insert),
    .pad_load    (pad_load),
    .update_done (update_done)
  );

  // evaluation result check against the window around the last codes
  wire eval_accept = eval_done && eval_busy;
  wire comp_oor    = eval_accept &&
                     (code_out_of_range(codes_reg.pullup_strength_code,
                                        eval_codes.pullup_strength_code, comp_range) ||
                      code_out_of_range(codes_reg.pulldown_strength_code,
                                        eval_codes.pulldown_strength_code, comp_range));

  // event set terms; flags record regardless of the enables
  irq_vec_t ev_set;
  assign ev_set.comp_done        = comp_oor;
  assign ev_set.offset_range     = offset_out_of_range;
  assign ev_set.delay_programmed = delay_programmed;

  // clear terms: a completed status read, or a one written to the flag
  irq_vec_t ev_clr;
  assign ev_clr = irq_vec_t'(({IRQ_N{rd_sts}}) |
                  ({IRQ_N{wr_sts}} & avs_writedata[IRQ_LSB +: IRQ_N]
                   & {IRQ_N{avs_byteenable[3]}}));

  // set beats clear so an event landing on the clear is kept
  assign flags_next = irq_vec_t'(ev_set | (flags_reg & ~ev_clr));

  // interrupt: status gated by the enable bits of the same layout
  assign irq = |(flags_reg & irq_enable_reg[IRQ_LSB +: IRQ_N]);

  // software bits of the compensation control word; hardware clears the
  // trigger and update bits once their work is done, a write in the same
  // cycle wins so a fresh request is never dropped
  always_comb begin
    pad_comp_ctrl_next = pad_comp_ctrl_reg;
    if (sw_done) pad_comp_ctrl_next[COMP_SW_EVAL_BIT] = 1'b0;
    if (update_done) pad_comp_ctrl_next[COMP_UPDATE_BIT] = 1'b0;
    if (wr_comp) begin
      pad_comp_ctrl_next = be_merge(pad_comp_ctrl_next,
                                    avs_writedata & COMP_MASK,
                                    avs_byteenable);
    end
  end

  // read-only views
  logic [31:0] status_view;
  logic [31:0] delay_view;
  assign status_view = {flags_reg,
                        codes_reg.pullup_strength_code,
                        codes_reg.pulldown_strength_code,
                        phase_value,
                        self_refresh_flag,
                        offset_value};

  // each strobe field follows its line live, so hardware and software
  // loaded delays both show without any shadow copy going stale
  genvar g;
  generate
    for (g = 0; g < STROBE_N; g++) begin : g_dly
      assign delay_view[g*STROBE_PITCH +: STROBE_PITCH] =
        {1'b0, strobe_delay_value[g]};
    end
  endgenerate

  // read mux; unmapped words and reserved bits read as zero
  wire [31:0] rd_mux = sel_en   ? (irq_enable_reg & IRQ_MASK) :
                       sel_sts  ? status_view :
                       sel_dly  ? delay_view :
                       sel_pin  ? (pin_if_ctrl_reg & PIN_MASK) :
                       sel_comp ? (pad_comp_ctrl_reg & COMP_MASK) :
                       32'h0000_0000;

  // pin interface outputs straight from the control register
  assign pin_ctrl.strobe_pulldown_ctrl   = pin_if_ctrl_reg[PIN_PULLDOWN_BIT];
  assign pin_ctrl.strobe_weak_pull_ctrl  = pin_if_ctrl_reg[PIN_WEAK_PULL_BIT];
  assign pin_ctrl.cmd_pad_hysteresis_en  = pin_if_ctrl_reg[PIN_CMD_HYST_BIT];
  assign pin_ctrl.data_pad_hysteresis_en = pin_if_ctrl_reg[PIN_DATA_HYST_BIT];

  // pads keep their old drive until the quiet window loads the new one
  assign pad_drive_applied = pad_drive_applied_reg;

  // bus handshake and read data capture
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_reg      <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg      <= req && !ack_reg;
      if (avs_read && !ack_reg) readdata_reg <= rd_mux;
    end
  end

  // software-written control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_enable_reg    <= RST_IRQ_ENABLE;
      pin_if_ctrl_reg   <= RST_PIN_IF_CTRL;
      pad_comp_ctrl_reg <= RST_PAD_COMP_CTRL;
    end else begin
      if (wr_en) irq_enable_reg <= be_merge(irq_enable_reg,
                                            avs_writedata & IRQ_MASK,
                                            avs_byteenable);
      if (wr_pin) pin_if_ctrl_reg <= be_merge(pin_if_ctrl_reg,
                                              avs_writedata & PIN_MASK,
                                              avs_byteenable);
      pad_comp_ctrl_reg <= pad_comp_ctrl_next;
    end
  end

  // sticky flags and last accepted compensation codes
  always_ff @(posedge clk) begin
    if (reset) begin
      flags_reg <= '0;
      codes_reg <= '0;
    end else begin
      flags_reg <= flags_next;
      if (eval_accept) codes_reg <= eval_codes;
    end
  end

  // drive settings load only inside the quiet window
  always_ff @(posedge clk) begin
    if (reset) begin
      pad_drive_applied_reg <= '0;
    end else if (pad_load) begin
      pad_drive_applied_reg <= pad_drive_pending;
    end
  end

endmodule // memory_ctrl_status_and_comp_regs

`default_nettype wire

/* verilog/memory_ctrl_pkg.sv */
/*
  memory_ctrl_pkg: register map, field positions, reset values and timing
  figures shared by the memory controller status and compensation block.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
`default_nettype none

package memory_ctrl_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS    = 8'h04;
  localparam logic [7:0] OFS_STROBE_DELAY  = 8'h08;
  localparam logic [7:0] OFS_PIN_IF_CTRL   = 8'h0C;
  localparam logic [7:0] OFS_PAD_COMP_CTRL = 8'h10;

  // interrupt bits, same layout in enable and status
  localparam int IRQ_COMP_DONE_BIT  = 31;
  localparam int IRQ_OFFSET_BIT     = 30;
  localparam int IRQ_DELAY_PROG_BIT = 29;
  localparam int IRQ_LSB            = 29;
  localparam int IRQ_N              = 3;

  // irq_status read-only fields
  localparam int STS_PULLUP_LSB   = 22;
  localparam int STS_PULLDN_LSB   = 15;
  localparam int STS_PHASE_LSB    = 8;
  localparam int STS_SELF_REF_BIT = 7;
  localparam int STS_OFFSET_LSB   = 0;
  localparam int CODE_W           = 7;

  // strobe_delay_status: one field per data strobe line, a byte lane each
  localparam int STROBE_N       = 4;
  localparam int STROBE_FIELD_W = 7;
  localparam int STROBE_PITCH   = 8;

  // pin_interface_ctrl fields
  localparam int PIN_PULLDOWN_BIT  = 31;
  localparam int PIN_WEAK_PULL_BIT = 30;
  localparam int PIN_CMD_HYST_BIT  = 29;
  localparam int PIN_DATA_HYST_BIT = 28;
  localparam int PIN_MUST_ONE_BIT  = 26;

  // pad_comp_ctrl fields
  localparam int COMP_SW_EVAL_BIT  = 31;
  localparam int COMP_UPDATE_BIT   = 30;
  localparam int COMP_RANGE_LSB    = 25;
  localparam int COMP_RANGE_W      = 5;
  localparam int COMP_MUST_ONE_BIT = 24;
  localparam int EVAL_INTERVAL_W   = 20;

  // reset values
  localparam logic [31:0] RST_IRQ_ENABLE    = 32'h0000_0000;
  localparam logic [31:0] RST_PIN_IF_CTRL   = 32'h0000_0000;
  localparam logic [31:0] RST_PAD_COMP_CTRL = 32'h0000_0000;

  // timing figures
  localparam int CLK_HZ          = 20_000_000;
  localparam int REF_CLK_HZ      = 13_000_000;
  localparam int PAD_NOP_CYCLES  = 4;
  localparam int PAD_LOAD_AT     = 1;

  typedef struct packed {
    logic strobe_pulldown_ctrl;
    logic strobe_weak_pull_ctrl;
    logic cmd_pad_hysteresis_en;
    logic data_pad_hysteresis_en;
  } pin_ctrl_t;

  typedef struct packed {
    logic [CODE_W-1:0] pullup_strength_code;
    logic [CODE_W-1:0] pulldown_strength_code;
  } comp_codes_t;

  typedef struct packed {
    logic comp_done;
    logic offset_range;
    logic delay_programmed;
  } irq_vec_t;

endpackage

`default_nettype wire

/* verilog/comp_eval_sched.sv */
/*
  comp_eval_sched: schedules compensation evaluations from the 13 MHz
  reference tick and from the software trigger bit.
  Assumes ref_tick is a one-cycle pulse per reference period, synchronous
  to clk, and eval_done is a one-cycle pulse from the evaluation circuit.
*/
`default_nettype none
`timescale 1ns/1ps

module comp_eval_sched
  import memory_ctrl_pkg::*;
#(
  parameter int INTERVAL_W = EVAL_INTERVAL_W
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  ref_tick,
  input  wire logic [INTERVAL_W-1:0] interval,
  input  wire logic                  sw_trigger,
  input  wire logic                  eval_done,
  output logic                       eval_start,
  output logic                       eval_busy,
  output logic                       sw_done
);

  logic [INTERVAL_W-1:0] cnt_reg;
  logic [INTERVAL_W-1:0] cnt_next;
  logic                  busy_reg;
  logic                  sw_owned_reg;
  wire                   interval_on = (interval != '0);
  wire                   wrap        = ref_tick && interval_on
                                       && ((cnt_reg + 1'b1) >= interval);
  wire                   done_ok     = eval_done && busy_reg;

  // reference-tick counter, same scheme as the refresh interval counter
  assign cnt_next   = !interval_on ? '0 :
                      wrap         ? '0 :
                      ref_tick     ? INTERVAL_W'(cnt_reg + 1'b1) : cnt_reg;
  // a hardware slot that hits a running evaluation is skipped, not queued
  assign eval_start = !busy_reg && (wrap || sw_trigger);
  assign eval_busy  = busy_reg;
  assign sw_done    = done_ok && sw_owned_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg      <= '0;
      busy_reg     <= 1'b0;
      sw_owned_reg <= 1'b0;
    end else begin
      cnt_reg      <= cnt_next;
      busy_reg     <= eval_start ? 1'b1 : (done_ok ? 1'b0 : busy_reg);
      sw_owned_reg <= eval_start ? sw_trigger : (done_ok ? 1'b0 : sw_owned_reg);
    end
  end

endmodule // comp_eval_sched

`default_nettype wire

/* verilog/pad_update_seq.sv */
/*
  pad_update_seq: opens the quiet window of idle cycles on the memory
  interface and loads the pad drivers inside it.
  Assumes the command scheduler issues a no-operation in every cycle that
  nop_insert is high.
*/
`default_nettype none
`timescale 1ns/1ps

module pad_update_seq
  import memory_ctrl_pkg::*;
#(
  parameter int NOP_CYCLES = PAD_NOP_CYCLES,
  parameter int LOAD_AT    = PAD_LOAD_AT
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic update_req,
  output logic      nop_insert,
  output logic      pad_load,
  output logic      update_done
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_QUIET = 3'b010,
    ST_DONE  = 3'b100
  } upd_state_t;

  upd_state_t state_reg;
  upd_state_t state_next;
  logic [2:0] cnt_reg;
  wire        last = (cnt_reg == 3'(NOP_CYCLES - 1));

  // next state of the quiet window
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  if (update_req) state_next = ST_QUIET;
      ST_QUIET: if (last) state_next = ST_DONE;
      ST_DONE:  state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  // drivers change mid-window so no command sees a half-updated pad
  assign nop_insert  = (state_reg == ST_QUIET);
  assign pad_load    = nop_insert && (cnt_reg == 3'(LOAD_AT));
  assign update_done = (state_reg == ST_DONE);

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 3'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= nop_insert ? 3'(cnt_reg + 1'b1) : 3'h0;
    end
  end

endmodule // pad_update_seq

`default_nettype wire

/* verif/memory_ctrl_chk.sv */
/*
  memory_ctrl_chk: concurrent checks on the ports of the register bank.
  Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module memory_ctrl_chk
  import memory_ctrl_pkg::*;
#(
  parameter int DRIVE_W = 32
) (
  input wire logic                                    clk,
  input wire logic                                    reset,
  input wire logic [7:0]                              avs_address,
  input wire logic                                    avs_read,
  input wire logic                                    avs_write,
  input wire logic [31:0]                             avs_writedata,
  input wire logic [3:0]                              avs_byteenable,
  input wire logic [31:0]                             avs_readdata,
  input wire logic                                    avs_waitrequest,
  input wire logic                                    irq,
  input wire logic                                    eval_start,
  input wire logic                                    eval_done,
  input wire logic                                    offset_out_of_range,
  input wire logic                                    delay_programmed,
  input wire logic [STROBE_N-1:0][STROBE_FIELD_W-1:0] strobe_delay_value,
  input wire logic [DRIVE_W-1:0]                      pad_drive_pending,
  input wire logic [DRIVE_W-1:0]                      pad_drive_applied,
  input wire logic                                    nop_insert,
  input wire pin_ctrl_t                               pin_ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // expected strobe status word; top bit of each byte lane reads zero
  logic [31:0] dly_word;
  logic        wr_done;
  wire         cause = offset_out_of_range || delay_programmed || eval_done || avs_write;
  assign dly_word = {1'b0, strobe_delay_value[3], 1'b0, strobe_delay_value[2],
                     1'b0, strobe_delay_value[1], 1'b0, strobe_delay_value[0]};
  assign wr_done  = avs_write && !avs_waitrequest && avs_byteenable[3];

  irq_rise_a: assert property (
    $rose(irq) |-> $past(cause))
    else $error("irq rose without a cause");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(avs_read) || $past(avs_write)) else $error("irq fell without a bus access");
  irq_mask_a: assert property (
    wr_done && avs_address == OFS_IRQ_ENABLE && avs_writedata[31:29] == 3'b000 |=> !irq)
    else $error("irq high with all enables off");
  ro_delay_a: assert property (
    avs_read && !avs_waitrequest && avs_address == OFS_STROBE_DELAY |-> avs_readdata == $past(dly_word))
    else $error("strobe status differs from delay lines");
  nop_len_a: assert property (
    $rose(nop_insert) |-> nop_insert [*4] ##1 !nop_insert) else $error("idle window not four cycles");
  pad_hold_a: assert property (
    $changed(pad_drive_applied) |-> nop_insert) else $error("pad drive changed outside window");
  pad_load_a: assert property (
    $rose(nop_insert) |-> ##2 pad_drive_applied == $past(pad_drive_pending))
    else $error("pad drive not loaded in window");
  start_pulse_a: assert property (
    eval_start |=> !eval_start) else $error("evaluation start longer than one cycle");
  pin_map_a: assert property (
    wr_done && avs_address == OFS_PIN_IF_CTRL |=> pin_ctrl == $past(avs_writedata[31:28]))
    else $error("pin control outputs do not follow write");

  cover property ($rose(nop_insert));
  cover property ($rose(irq));
  cover property (eval_start);
endmodule // memory_ctrl_chk

bind memory_ctrl_status_and_comp_regs memory_ctrl_chk #(.DRIVE_W(DRIVE_W)) memory_ctrl_chk_inst (
  .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .irq, .eval_start, .eval_done, .offset_out_of_range,
  .delay_programmed, .strobe_delay_value, .pad_drive_pending, .pad_drive_applied,
  .nop_insert, .pin_ctrl);

`default_nettype wire

/* verif/tb_memory_ctrl_status_and_comp_regs.sv */
/*
  tb_memory_ctrl_status_and_comp_regs: self-checking bench for the register bank.
  Assumes the package is compiled first; one 20 MHz clock, Avalon-MM master in the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_memory_ctrl_status_and_comp_regs;
  import memory_ctrl_pkg::*;
  logic                  clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic                  ref_tick = 1'b0, eval_done = 1'b0, self_refresh_flag = 1'b1;
  logic                  offset_out_of_range = 1'b0, delay_programmed = 1'b0;
  logic                  avs_waitrequest, irq, eval_start, nop_insert;
  logic [7:0]            avs_address = 8'h00;
  logic [3:0]            avs_byteenable = 4'hF;
  logic [31:0]           avs_writedata = 32'h0000_0000, avs_readdata, rd, pad_drive_applied;
  logic [31:0]           pad_drive_pending = 32'hA5A5_5A5A;
  logic [6:0]            phase_value = 7'h55, offset_value = 7'h2A;
  logic [3:0][6:0]       strobe_delay_value = {7'h7F, 7'h01, 7'h40, 7'h33};
  comp_codes_t           eval_codes = '0;
  pin_ctrl_t             pin_ctrl;
  int                    n_mismatch = 0, check_count = 0, cyc = 0, n_start = 0, n_nop = 0;

  memory_ctrl_status_and_comp_regs #(.DRIVE_W(32)) memory_ctrl_status_and_comp_regs_inst (
    .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .irq, .ref_tick, .eval_start, .eval_done, .eval_codes,
    .phase_value, .offset_value, .self_refresh_flag, .offset_out_of_range, .delay_programmed,
    .strobe_delay_value, .pad_drive_pending, .pad_drive_applied, .nop_insert, .pin_ctrl);

  always #25 clk = ~clk;

  // pulse counters and a watchdog; a run of under two hundred cycles is expected
  always @(posedge clk) begin
    n_start <= n_start + int'(eval_start === 1'b1);
    n_nop <= n_nop + int'(nop_insert === 1'b1);
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus access; holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // one-cycle pulse: 0 offset event, 1 delay event, 2 reference tick, 3 evaluation done
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: offset_out_of_range <= 1'b1;
      1: delay_programmed <= 1'b1;
      2: ref_tick <= 1'b1;
      default: eval_done <= 1'b1;
    endcase
    @(posedge clk);
    {offset_out_of_range, delay_programmed, ref_tick, eval_done} <= 4'h0;
  endtask

  task automatic t_reset();
    rchk(OFS_IRQ_ENABLE, RST_IRQ_ENABLE);
    rchk(OFS_PIN_IF_CTRL, RST_PIN_IF_CTRL);
    rchk(OFS_PAD_COMP_CTRL, RST_PAD_COMP_CTRL);
    chk(32'(irq), 32'h0000_0000);
  endtask

  // flags record with enables off; masking, read clear and write-one clear
  task automatic t_irq();
    bus(1'b1, OFS_IRQ_ENABLE, 32'hFFFF_FFFF);
    rchk(OFS_IRQ_ENABLE, 32'hE000_0000);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h0000_0000);
    pulse(0);
    pulse(1);
    chk(32'(irq), 32'h0000_0000);
    rchk(OFS_IRQ_STATUS, 32'h6000_55AA);
    rchk(OFS_IRQ_STATUS, 32'h0000_55AA);
    bus(1'b1, OFS_IRQ_ENABLE, 32'h2000_0000);
    pulse(0);
    @(posedge clk);
    chk(32'(irq), 32'h0000_0000);
    pulse(1);
    @(posedge clk);
    chk(32'(irq), 32'h0000_0001);
    bus(1'b1, OFS_IRQ_STATUS, 32'h2000_0000);
    @(posedge clk);
    chk(32'(irq), 32'h0000_0000);
    rchk(OFS_IRQ_STATUS, 32'h4000_55AA);
  endtask

  // read-only strobe view follows the lines; writes and unmapped places drop
  task automatic t_strobe();
    bus(1'b1, OFS_STROBE_DELAY, 32'hFFFF_FFFF);
    rchk(OFS_STROBE_DELAY, 32'h7F01_4033);
    strobe_delay_value[1] <= 7'h05;
    rchk(OFS_STROBE_DELAY, 32'h7F01_0533);
    bus(1'b1, 8'h20, 32'hFFFF_FFFF);
    rchk(8'h20, 32'h0000_0000);
  endtask

  task automatic t_pin();
    bus(1'b1, OFS_PIN_IF_CTRL, 32'hFFFF_FFFF);
    rchk(OFS_PIN_IF_CTRL, 32'hF400_0000);
    chk(32'(pin_ctrl), 32'h0000_000F);
    bus(1'b1, OFS_PIN_IF_CTRL, 32'h4400_0000);
    @(posedge clk);
    chk(32'(pin_ctrl), 32'h0000_0004);
  endtask

  // software evaluation with range 2; result judged against stored codes
  task automatic eval_sw(input logic [13:0] codes, input logic [31:0] exp_sts);
    int s;
    s = n_start;
    bus(1'b1, OFS_PAD_COMP_CTRL, 32'h8500_0000);
    repeat (3) @(posedge clk);
    chk(32'(n_start - s), 32'h0000_0001);
    eval_codes <= codes;
    pulse(3);
    rchk(OFS_PAD_COMP_CTRL, 32'h0500_0000);
    rchk(OFS_IRQ_STATUS, exp_sts);
  endtask

  task automatic t_eval();
    int s;
    eval_sw({7'h10, 7'h00}, 32'h8400_55AA);
    eval_sw({7'h11, 7'h01}, 32'h0440_D5AA);
    s = n_start;
    bus(1'b1, OFS_PAD_COMP_CTRL, 32'h0500_0003);
    pulse(2);
    pulse(2);
    repeat (3) @(posedge clk);
    chk(32'(n_start - s), 32'h0000_0000);
    pulse(2);
    repeat (3) @(posedge clk);
    chk(32'(n_start - s), 32'h0000_0001);
    pulse(3);
    bus(1'b1, OFS_PAD_COMP_CTRL, 32'h0100_0000);
  endtask

  // pad drive held until the update bit, then loaded inside four idle cycles
  task automatic t_pad();
    int s;
    chk(pad_drive_applied, 32'h0000_0000);
    s = n_nop;
    bus(1'b1, OFS_PAD_COMP_CTRL, 32'h4100_0000);
    repeat (8) @(posedge clk);
    chk(32'(n_nop - s), 32'h0000_0004);
    chk(pad_drive_applied, 32'hA5A5_5A5A);
    rchk(OFS_PAD_COMP_CTRL, 32'h0100_0000);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_irq();
    t_strobe();
    t_pin();
    t_eval();
    t_pad();
    end_sim();
  end
endmodule // tb_memory_ctrl_status_and_comp_regs

`default_nettype wire
